/* File: core/fb_divider.sv */
// Counting divider with a small selectable output delay
`timescale 1ns/1ps

module fb_divider #(
  parameter int W = 14
) (
  // Clock and reset
  input  wire logic         clock,
  input  wire logic         resetn,
  input  wire logic         ce,
  // Divider
  input  wire logic         tick,
  input  wire logic [W-1:0] divide,
  input  wire logic [2:0]   delayCode,
  output logic              edgeOut
);

  logic [W-1:0] count_q;
  logic [7:0]   delayLine_q;
  wire  [W-1:0] lastCount = (divide > W'(1)) ? divide - W'(1) : '0;
  wire          wrap      = tick && (count_q >= lastCount);

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      count_q     <= '0;
      delayLine_q <= 8'h00;
      edgeOut     <= 1'b0;
    end else if (ce) begin
      if (tick) begin
        count_q <= wrap ? '0 : count_q + W'(1);
      end
      delayLine_q <= {delayLine_q[6:0], wrap};
      // Each code step adds one clock of delay, the finest step available here
      edgeOut     <= (delayCode == 3'h0) ? wrap : delayLine_q[delayCode - 3'h1];
    end
  end

endmodule

/* File: core/lock_edge_meter.sv */
// Measures spacing between paired rising edges at the two comparator inputs
`timescale 1ns/1ps

module lock_edge_meter (
  // Clock and reset
  input  wire logic       clock,
  input  wire logic       resetn,
  input  wire logic       ce,
  // Edges
  input  wire logic       refEdge,
  input  wire logic       fbEdge,
  // Result
  output logic [7:0]      spacing,
  output logic            spacingValid,
  output logic            busy
);

  logic       pending_q;
  logic       refFirst_q;
  logic [7:0] count_q;

  wire sameEdge  = pending_q && (refFirst_q ? refEdge : fbEdge);
  wire otherEdge = pending_q && (refFirst_q ? fbEdge : refEdge);
  wire [7:0] countNext = (count_q == 8'hFF) ? count_q : count_q + 8'h01;

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      pending_q    <= 1'b0;
      refFirst_q   <= 1'b0;
      count_q      <= 8'h00;
      spacing      <= 8'h00;
      spacingValid <= 1'b0;
    end else if (ce) begin
      spacingValid <= 1'b0;
      if (!pending_q) begin
        count_q <= 8'h00;
        if (refEdge && fbEdge) begin
          spacing      <= 8'h00;
          spacingValid <= 1'b1;
        end else if (refEdge || fbEdge) begin
          pending_q  <= 1'b1;
          refFirst_q <= refEdge;
        end
      end else if (otherEdge) begin
        spacing      <= countNext;
        spacingValid <= 1'b1;
        pending_q    <= 1'b0;
      end else if (sameEdge) begin
        // A missing partner edge counts as the widest possible spacing
        spacing      <= 8'hFF;
        spacingValid <= 1'b1;
        count_q      <= 8'h00;
      end else begin
        count_q <= countNext;
      end
    end
  end

  assign busy = pending_q;

endmodule

/* File: core/pll_ld_defines.svh */
// Offsets, field positions, reset values and counts of the lock detect block
`ifndef PLL_LD_DEFINES_SVH
`define PLL_LD_DEFINES_SVH

// ****************************************
// Register offsets
// ****************************************
`define OFS_RDIV_LO      10'h011
`define OFS_RDIV_HI      10'h012
`define OFS_ACNT         10'h013
`define OFS_BCNT_LO      10'h014
`define OFS_BCNT_HI      10'h015
`define OFS_PRESCALE     10'h016
`define OFS_STATUS_CTL   10'h017
`define OFS_LOCK_CTL     10'h018
`define OFS_DELAY_CTL    10'h019
`define OFS_LDPIN_CTL    10'h01A
`define OFS_REFERENCE_MONITOR_PIN_CTL   10'h01B
`define OFS_IRQ_STAT     10'h0F0
`define OFS_IRQ_MASK     10'h0F1
`define OFS_LOCK_STAT    10'h0F2

// ****************************************
// Field positions
// ****************************************
`define FLD_ABP_LSB      0
`define FLD_STSEL_LSB    2
`define FLD_WINDOW       4
`define FLD_LDCNT_LSB    5
`define FLD_DLD_OFF      3
`define FLD_NDLY_LSB     0
`define FLD_RDLY_LSB     3
`define IRQ_GAINED       0
`define IRQ_LOST         1
`define IRQ_CFGERR       2

// ****************************************
// Reset values
// ****************************************
`define RST_RDIV         14'h0001
`define RST_ACNT         6'h00
`define RST_BCNT         13'h0003
`define RST_PRESCALE     3'h0
`define RST_CTL          8'h00

// ****************************************
// Selector codes
// ****************************************
`define LDSEL_DLD        6'h00
`define LDSEL_ALD_N      6'h01
`define LDSEL_ALD_P      6'h02
`define LDSEL_CURRENT    6'h04
`define MON_DLD          6'h01
`define MON_COMP_HI      6'h02
`define MON_COMP_LO      6'h03

// ****************************************
// Lock counts in edge pairs, windows in clock cycles
// ****************************************
`define LDCNT_0          8'h05
`define LDCNT_1          8'h10
`define LDCNT_2          8'h40
`define LDCNT_3          8'hFF
`define LK_THR_HI        8'h04
`define UL_THR_HI        8'h08
`define LK_THR_LO        8'h01
`define UL_THR_LO        8'h03
`define DELAY_RANGE_NS   1
`define CLK_PERIOD_NS    8
`define DELAY_STEP_CYC   ((`DELAY_RANGE_NS / `CLK_PERIOD_NS) < 1 ? 1 : \
                          (`DELAY_RANGE_NS / `CLK_PERIOD_NS))

`endif

/* File: core/pll_ld_pkg.sv */
// Types shared by the lock detect and divider configuration block
package pll_ld_pkg;

  // ****************************************
  // Prescaler modes
  // ****************************************
  typedef enum logic [2:0] {
    PS_FD1, PS_FD2, PS_FD3, PS_DM2, PS_DM4, PS_DM8, PS_DM16, PS_DM32
  } prescale_t;

  typedef enum logic {LK_SEEK, LK_HELD} lock_state_t;

  typedef struct packed {
    prescale_t   mode;
    logic [5:0]  aCnt;
    logic [12:0] bCnt;
  } div_cfg_t;

  typedef struct packed {
    logic [1:0] lockCnt;
    logic       window;
    logic       dldOff;
    logic [1:0] antiBacklash;
  } lock_cfg_t;

endpackage

/* File: core/pll_lock_detect.sv */
// Digital lock detection, lock pin routing and feedback divider configuration
//
// Local design decisions: strobed register access and the register offsets.
`timescale 1ns/1ps
`include "pll_ld_defines.svh"

module pll_lock_detect #(
  parameter int RW = 14,
  parameter int BW = 13
) (
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        resetn,
  input  wire logic        ce,
  // Register port
  input  wire logic [9:0]  regAddr,
  input  wire logic [7:0]  regWrData,
  input  wire logic        regWrEn,
  input  wire logic        regRdEn,
  output logic [7:0]       regRdData,
  // Divider ticks
  input  wire logic        refTick,
  input  wire logic        vcoTick,
  // Lock pin
  input  wire logic        ldCompIn,
  output logic             ldPinOut,
  output logic             ldPinDriveN,
  output logic             ldCurrentOn,
  // Monitor pins
  output logic             statusPin,
  output logic             refmonPin,
  output logic             digitalLockFlag,
  output logic             irq
);

  // ****************************************
  // Elaboration checks
  // ****************************************
  if (RW < 9 || RW > 16) begin : g_rw_bad
    $error("RW must lie between 9 and 16");
  end
  if (BW < 9 || BW > 16) begin : g_bw_bad
    $error("BW must lie between 9 and 16");
  end

  // ****************************************
  // Configuration registers
  // ****************************************
  logic [RW-1:0]          rDiv_q;
  pll_ld_pkg::div_cfg_t   divCfg_q;
  pll_ld_pkg::lock_cfg_t  lockCfg_q;
  logic [5:0]             statusSel_q;
  logic [5:0]             ldSel_q;
  logic [4:0]             refmonSel_q;
  logic [2:0]             rDelay_q;
  logic [2:0]             nDelay_q;
  logic [2:0]             irqStat_q;
  logic [2:0]             irqMask_q;

  wire selRLo    = (regAddr == `OFS_RDIV_LO);
  wire selRHi    = (regAddr == `OFS_RDIV_HI);
  wire selA      = (regAddr == `OFS_ACNT);
  wire selBLo    = (regAddr == `OFS_BCNT_LO);
  wire selBHi    = (regAddr == `OFS_BCNT_HI);
  wire selPs     = (regAddr == `OFS_PRESCALE);
  wire selStCtl  = (regAddr == `OFS_STATUS_CTL);
  wire selLkCtl  = (regAddr == `OFS_LOCK_CTL);
  wire selDlyCtl = (regAddr == `OFS_DELAY_CTL);
  wire selLdCtl  = (regAddr == `OFS_LDPIN_CTL);
  wire selRmCtl  = (regAddr == `OFS_REFERENCE_MONITOR_PIN_CTL);
  wire selIrqSt  = (regAddr == `OFS_IRQ_STAT);
  wire selIrqMk  = (regAddr == `OFS_IRQ_MASK);
  wire selLkSt   = (regAddr == `OFS_LOCK_STAT);

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      rDiv_q      <= RW'(`RST_RDIV);
      divCfg_q    <= '{mode: pll_ld_pkg::PS_FD1, aCnt: `RST_ACNT, bCnt: BW'(`RST_BCNT)};
      lockCfg_q   <= '0;
      statusSel_q <= 6'h00;
      ldSel_q     <= 6'h00;
      refmonSel_q <= 5'h00;
      rDelay_q    <= 3'h0;
      nDelay_q    <= 3'h0;
      irqMask_q   <= 3'h0;
    end else if (ce && regWrEn) begin
      if (selRLo) begin
        rDiv_q[7:0] <= regWrData;
      end else if (selRHi) begin
        rDiv_q[RW-1:8] <= regWrData[RW-9:0];
      end else if (selA) begin
        divCfg_q.aCnt <= regWrData[5:0];
      end else if (selBLo) begin
        divCfg_q.bCnt[7:0] <= regWrData;
      end else if (selBHi) begin
        divCfg_q.bCnt[BW-1:8] <= regWrData[BW-9:0];
      end else if (selPs) begin
        divCfg_q.mode <= pll_ld_pkg::prescale_t'(regWrData[2:0]);
      end else if (selStCtl) begin
        statusSel_q            <= regWrData[7:`FLD_STSEL_LSB];
        lockCfg_q.antiBacklash <= regWrData[`FLD_ABP_LSB +: 2];
      end else if (selLkCtl) begin
        lockCfg_q.lockCnt <= regWrData[`FLD_LDCNT_LSB +: 2];
        lockCfg_q.window  <= regWrData[`FLD_WINDOW];
        lockCfg_q.dldOff  <= regWrData[`FLD_DLD_OFF];
      end else if (selDlyCtl) begin
        nDelay_q <= regWrData[`FLD_NDLY_LSB +: 3];
        rDelay_q <= regWrData[`FLD_RDLY_LSB +: 3];
      end else if (selLdCtl) begin
        ldSel_q <= regWrData[5:0];
      end else if (selRmCtl) begin
        refmonSel_q <= regWrData[4:0];
      end else if (selIrqMk) begin
        irqMask_q <= regWrData[2:0];
      end
    end
  end

  // ****************************************
  // Feedback divide ratio
  // ****************************************
  localparam int NW = BW + 6;

  wire [5:0] pValue =
    (divCfg_q.mode == pll_ld_pkg::PS_FD1)  ? 6'h01 :
    (divCfg_q.mode == pll_ld_pkg::PS_FD2)  ? 6'h02 :
    (divCfg_q.mode == pll_ld_pkg::PS_FD3)  ? 6'h03 :
    (divCfg_q.mode == pll_ld_pkg::PS_DM2)  ? 6'h02 :
    (divCfg_q.mode == pll_ld_pkg::PS_DM4)  ? 6'h04 :
    (divCfg_q.mode == pll_ld_pkg::PS_DM8)  ? 6'h08 :
    (divCfg_q.mode == pll_ld_pkg::PS_DM16) ? 6'h10 : 6'h20;
  wire          dualMod  = (divCfg_q.mode >= pll_ld_pkg::PS_DM2);
  wire          bBypass  = (divCfg_q.bCnt == BW'(1));
  wire [NW-1:0] pTimesB  = NW'(pValue) * NW'(divCfg_q.bCnt);
  wire [NW-1:0] aTerm    = (dualMod && !bBypass) ? NW'(divCfg_q.aCnt) : '0;
  wire [NW-1:0] nDivide  = bBypass ? NW'(pValue) : pTimesB + aTerm;
  // Illegal settings are flagged, not corrected: A above B in a dual-modulus mode, or B of two
  wire          cfgBad   = (dualMod && (BW'(divCfg_q.aCnt) > divCfg_q.bCnt)) ||
                           (divCfg_q.bCnt == BW'(2));

  // ****************************************
  // R and N dividers with delay cells
  // ****************************************
  logic refEdge;
  logic fbEdge;

  fb_divider #(.W(RW)) u_rdiv (
    .clock     (clock),
    .resetn    (resetn),
    .ce        (ce),
    .tick      (refTick),
    .divide    (rDiv_q),
    .delayCode (rDelay_q),
    .edgeOut   (refEdge)
  );

  fb_divider #(.W(NW)) u_ndiv (
    .clock     (clock),
    .resetn    (resetn),
    .ce        (ce),
    .tick      (vcoTick),
    .divide    (nDivide),
    .delayCode (nDelay_q),
    .edgeOut   (fbEdge)
  );

  // ****************************************
  // Edge spacing and lock state
  // ****************************************
  logic [7:0] spacing;
  logic       spacingValid;
  logic       meterBusy;

  lock_edge_meter u_meter (
    .clock        (clock),
    .resetn       (resetn),
    .ce           (ce),
    .refEdge      (refEdge),
    .fbEdge       (fbEdge),
    .spacing      (spacing),
    .spacingValid (spacingValid),
    .busy         (meterBusy)
  );

  // Unlock window always sits above the lock window by construction
  wire [7:0] abpCyc    = 8'(lockCfg_q.antiBacklash);
  wire [7:0] lockThr   = (lockCfg_q.window ? `LK_THR_LO : `LK_THR_HI) + abpCyc;
  wire [7:0] unlockThr = (lockCfg_q.window ? `UL_THR_LO : `UL_THR_HI) + abpCyc;
  wire [7:0] needCount =
    (lockCfg_q.lockCnt == 2'h0) ? `LDCNT_0 :
    (lockCfg_q.lockCnt == 2'h1) ? `LDCNT_1 :
    (lockCfg_q.lockCnt == 2'h2) ? `LDCNT_2 : `LDCNT_3;

  pll_ld_pkg::lock_state_t lockState_q;
  pll_ld_pkg::lock_state_t lockState_d;
  logic [7:0]              goodCount_q;
  logic [7:0]              goodCount_d;

  wire closeEdge = spacing < lockThr;
  wire wideEdge  = spacing > unlockThr;

  always_comb begin
    lockState_d = lockState_q;
    goodCount_d = goodCount_q;
    if (lockCfg_q.dldOff) begin
      lockState_d = pll_ld_pkg::LK_SEEK;
      goodCount_d = 8'h00;
    end else if (spacingValid) begin
      case (lockState_q)
        pll_ld_pkg::LK_SEEK: begin
          if (!closeEdge) begin
            goodCount_d = 8'h00;
          end else if (goodCount_q + 8'h01 >= needCount) begin
            lockState_d = pll_ld_pkg::LK_HELD;
            goodCount_d = 8'h00;
          end else begin
            goodCount_d = goodCount_q + 8'h01;
          end
        end
        pll_ld_pkg::LK_HELD: begin
          if (wideEdge) begin
            lockState_d = pll_ld_pkg::LK_SEEK;
          end
        end
        default: lockState_d = pll_ld_pkg::LK_SEEK;
      endcase
    end
  end

  wire lockNow  = (lockState_d == pll_ld_pkg::LK_HELD);
  wire gained   = lockNow && (lockState_q == pll_ld_pkg::LK_SEEK);
  wire lost     = !lockNow && (lockState_q == pll_ld_pkg::LK_HELD);

  // ****************************************
  // Pin selection
  // ****************************************
  // Analog lock pulse spans the time between the two paired edges
  wire aldPulse = meterBusy;
  wire ldPinOutD =
    (ldSel_q == `LDSEL_DLD)     ? lockNow :
    (ldSel_q == `LDSEL_ALD_N)   ? 1'b0 :
    (ldSel_q == `LDSEL_ALD_P)   ? 1'b1 : 1'b0;
  wire ldDriveND =
    (ldSel_q == `LDSEL_DLD)     ? 1'b0 :
    (ldSel_q == `LDSEL_ALD_N)   ? !aldPulse :
    (ldSel_q == `LDSEL_ALD_P)   ? !aldPulse :
    (ldSel_q == `LDSEL_CURRENT) ? lockNow : 1'b0;
  wire ldCurrentD = (ldSel_q == `LDSEL_CURRENT) && lockNow;

  wire statusD =
    (statusSel_q == `MON_DLD)     ? lockNow :
    (statusSel_q == `MON_COMP_HI) ? ldCompIn :
    (statusSel_q == `MON_COMP_LO) ? !ldCompIn : 1'b0;
  wire refmonD =
    (6'(refmonSel_q) == `MON_DLD)     ? lockNow :
    (6'(refmonSel_q) == `MON_COMP_HI) ? ldCompIn :
    (6'(refmonSel_q) == `MON_COMP_LO) ? !ldCompIn : 1'b0;

  // ****************************************
  // Interrupt status, set wins over clear
  // ****************************************
  wire [2:0] irqEvents = {cfgBad, lost, gained};
  wire [2:0] irqClear  = (ce && regWrEn && selIrqSt) ? regWrData[2:0] : 3'h0;
  wire [2:0] irqStatD  = (irqStat_q & ~irqClear) | irqEvents;

  // ****************************************
  // State, outputs and read data
  // ****************************************
  wire [7:0] rdMux =
    selRLo    ? rDiv_q[7:0] :
    selRHi    ? 8'(rDiv_q[RW-1:8]) :
    selA      ? {2'h0, divCfg_q.aCnt} :
    selBLo    ? divCfg_q.bCnt[7:0] :
    selBHi    ? 8'(divCfg_q.bCnt[BW-1:8]) :
    selPs     ? {5'h00, divCfg_q.mode} :
    selStCtl  ? {statusSel_q, lockCfg_q.antiBacklash} :
    selLkCtl  ? {1'b0, lockCfg_q.lockCnt, lockCfg_q.window, lockCfg_q.dldOff, 3'h0} :
    selDlyCtl ? {2'h0, rDelay_q, nDelay_q} :
    selLdCtl  ? {2'h0, ldSel_q} :
    selRmCtl  ? {3'h0, refmonSel_q} :
    selIrqSt  ? {5'h00, irqStat_q} :
    selIrqMk  ? {5'h00, irqMask_q} :
    selLkSt   ? {5'h00, cfgBad, ldCompIn, digitalLockFlag} : 8'h00;

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      lockState_q     <= pll_ld_pkg::LK_SEEK;
      goodCount_q     <= 8'h00;
      irqStat_q       <= 3'h0;
      digitalLockFlag <= 1'b0;
      ldPinOut        <= 1'b0;
      ldPinDriveN     <= 1'b0;
      ldCurrentOn     <= 1'b0;
      statusPin       <= 1'b0;
      refmonPin       <= 1'b0;
      irq             <= 1'b0;
      regRdData       <= 8'h00;
    end else if (ce) begin
      lockState_q     <= lockState_d;
      goodCount_q     <= goodCount_d;
      irqStat_q       <= irqStatD;
      digitalLockFlag <= lockNow;
      ldPinOut        <= ldPinOutD;
      ldPinDriveN     <= ldDriveND;
      ldCurrentOn     <= ldCurrentD;
      statusPin       <= statusD;
      refmonPin       <= refmonD;
      irq             <= |(irqStatD & irqMask_q);
      regRdData       <= regRdEn ? rdMux : 8'h00;
    end
  end

endmodule

/* File: test/ld_cap_model.sv */
// Lock pin load: pull-up, charging capacitor and pin comparator
`timescale 1ns/1ps

module ld_cap_model #(
  parameter int THR = 12
) (
  // Clock and reset
  input  wire logic clock,
  input  wire logic resetn,
  // Lock pin
  input  wire logic ldPinOut,
  input  wire logic ldPinDriveN,
  input  wire logic ldCurrentOn,
  output logic      pinLevel,
  output logic      ldCompIn
);
  logic [7:0] charge_q;

  // Released pin floats to the pull-up
  assign pinLevel = ldPinDriveN ? 1'b1 : ldPinOut;
  assign ldCompIn = charge_q >= 8'(THR);

  // A pin pulled low dumps the charge at once
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      charge_q <= 8'h00;
    end else if (!pinLevel) begin
      charge_q <= 8'h00;
    end else if (ldCurrentOn && charge_q != 8'hFF) begin
      charge_q <= charge_q + 8'h01;
    end
  end
endmodule

/* File: test/pll_ld_checker.sv */
// Port assertions for the lock detect block
`timescale 1ns/1ps
`include "pll_ld_defines.svh"

module pll_ld_checker (
  // Clock and reset
  input wire logic       clock,
  input wire logic       resetn,
  input wire logic       ce,
  // Register port
  input wire logic [9:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic       regWrEn,
  input wire logic       regRdEn,
  input wire logic [7:0] regRdData,
  // Pins
  input wire logic       ldCompIn,
  input wire logic       ldPinOut,
  input wire logic       ldPinDriveN,
  input wire logic       ldCurrentOn,
  input wire logic       statusPin,
  input wire logic       refmonPin,
  input wire logic       digitalLockFlag,
  input wire logic       irq
);
  // ********
  // Shadows
  // ********
  function automatic logic selOut(input logic [5:0] s, input logic f, input logic c);
    case (s)
      `MON_DLD:     return f;
      `MON_COMP_HI: return c;
      `MON_COMP_LO: return !c;
      default:      return 1'b0;
    endcase
  endfunction

  logic [5:0] ldSel_q;
  logic [5:0] stSel_q;
  logic [5:0] monSel_q;
  logic [2:0] mask_q;
  logic [2:0] lowCnt_q;

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      ldSel_q <= 6'h00;
      stSel_q <= 6'h00;
      monSel_q <= 6'h00;
      mask_q <= 3'h0;
    end else if (regWrEn && ce) begin
      if (regAddr == `OFS_LDPIN_CTL) ldSel_q <= regWrData[5:0];
      if (regAddr == `OFS_STATUS_CTL) stSel_q <= regWrData[7:2];
      if (regAddr == `OFS_REFERENCE_MONITOR_PIN_CTL) monSel_q <= {1'b0, regWrData[4:0]};
      if (regAddr == `OFS_IRQ_MASK) mask_q <= regWrData[2:0];
    end
  end

  // Saturates: only the minimum of five low cycles matters
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) lowCnt_q <= 3'h0;
    else if (digitalLockFlag) lowCnt_q <= 3'h0;
    else if (ce && lowCnt_q != 3'h7) lowCnt_q <= lowCnt_q + 3'h1;
  end

  // ********
  // Properties
  // ********
  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);

  sequence s_rdUnmapped;
    regRdEn && ce && regAddr == 10'h3FF;
  endsequence
  sequence s_lockRise;
    !digitalLockFlag ##1 digitalLockFlag;
  endsequence

  property p_rdIdle;
    !regRdEn && ce |=> regRdData == 8'h00;
  endproperty
  property p_rdUnmapped;
    s_rdUnmapped |=> regRdData == 8'h00;
  endproperty
  property p_ldFlag;
    ldSel_q == `LDSEL_DLD && ce |=> !ldPinDriveN && ldPinOut == digitalLockFlag;
  endproperty
  property p_ldCurrent;
    ldSel_q == `LDSEL_CURRENT && ce |=> ldCurrentOn == digitalLockFlag
      && ldPinDriveN == digitalLockFlag && (ldPinDriveN || !ldPinOut);
  endproperty
  property p_ldPulse;
    (ldSel_q == `LDSEL_ALD_N || ldSel_q == `LDSEL_ALD_P) && ce
      |=> ldPinDriveN || ldPinOut == $past(ldSel_q == `LDSEL_ALD_P);
  endproperty
  property p_reference_monitor_pin;
    ce |=> refmonPin == selOut($past(monSel_q), digitalLockFlag, $past(ldCompIn));
  endproperty
  property p_status;
    ce |=> statusPin == selOut($past(stSel_q), digitalLockFlag, $past(ldCompIn));
  endproperty
  property p_irqMask;
    mask_q == 3'h0 && ce |=> !irq;
  endproperty
  property p_lockCount;
    s_lockRise |-> lowCnt_q >= 3'h5;
  endproperty

  a_rdIdle: assert property (p_rdIdle) else $error("read data not zero when idle");
  a_rdUnmapped: assert property (p_rdUnmapped) else $error("unmapped read not zero");
  a_ldFlag: assert property (p_ldFlag) else $error("lock pin not the flag");
  a_ldCurrent: assert property (p_ldCurrent) else $error("current mode wrong");
  a_ldPulse: assert property (p_ldPulse) else $error("pulse polarity wrong");
  a_reference_monitor_pin: assert property (p_reference_monitor_pin) else $error("monitor pin wrong");
  a_status: assert property (p_status) else $error("status pin wrong");
  a_irqMask: assert property (p_irqMask) else $error("masked interrupt seen");
  a_lockCount: assert property (p_lockCount) else $error("lock flag too early");
endmodule

bind pll_lock_detect pll_ld_checker chk (
  .clock, .resetn, .ce, .regAddr, .regWrData, .regWrEn, .regRdEn, .regRdData,
  .ldCompIn, .ldPinOut, .ldPinDriveN, .ldCurrentOn, .statusPin, .refmonPin,
  .digitalLockFlag, .irq
);

/* File: test/tb.sv */
// Self-checking bench for the lock detect block
`timescale 1ns/1ps
`include "pll_ld_defines.svh"

module tb;
  logic        clock;
  logic        resetn;
  logic [9:0]  regAddr;
  logic [7:0]  regWrData;
  logic        regWrEn;
  logic        regRdEn;
  logic [7:0]  regRdData;
  logic        refTick;
  logic        vcoTick;
  logic        ldCompIn;
  logic        ldPinOut;
  logic        ldPinDriveN;
  logic        ldCurrentOn;
  logic        statusPin;
  logic        refmonPin;
  logic        digitalLockFlag;
  logic        irq;
  logic        pinLevel;
  logic        rdPend;
  logic [7:0]  expQ[$];
  logic [31:0] seed;
  int          err_count;
  int          checks;

  pll_lock_detect uut (
    .clock(clock), .resetn(resetn), .ce(1'b1), .regAddr(regAddr),
    .regWrData(regWrData), .regWrEn(regWrEn), .regRdEn(regRdEn),
    .regRdData(regRdData), .refTick(refTick), .vcoTick(vcoTick),
    .ldCompIn(ldCompIn), .ldPinOut(ldPinOut), .ldPinDriveN(ldPinDriveN),
    .ldCurrentOn(ldCurrentOn), .statusPin(statusPin), .refmonPin(refmonPin),
    .digitalLockFlag(digitalLockFlag), .irq(irq)
  );
  ld_cap_model model (
    .clock(clock), .resetn(resetn), .ldPinOut(ldPinOut), .ldPinDriveN(ldPinDriveN),
    .ldCurrentOn(ldCurrentOn), .pinLevel(pinLevel), .ldCompIn(ldCompIn)
  );

  initial clock = 1'b0;
  always #4 clock = ~clock;

  // ********
  // Tasks
  // ********
  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic test_done;
    $display("checks=%0d err_count=%0d", checks, err_count);
    if (err_count == 0 && checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  task automatic wr(input logic [9:0] a, input logic [7:0] d);
    @(posedge clock);
    regWrEn <= 1'b1;
    regAddr <= a;
    regWrData <= d;
    @(posedge clock);
    regWrEn <= 1'b0;
  endtask

  task automatic rd(input logic [9:0] a, input logic [7:0] e);
    @(posedge clock);
    regRdEn <= 1'b1;
    regAddr <= a;
    expQ.push_back(e);
    @(posedge clock);
    regRdEn <= 1'b0;
  endtask

  function automatic logic [31:0] xorshift(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction

  // One tick a clock keeps the prescaler input well under both rate limits
  task automatic tick(input int n);
    refTick <= 1'b1;
    vcoTick <= 1'b1;
    repeat (n) @(posedge clock);
    refTick <= 1'b0;
    vcoTick <= 1'b0;
  endtask

  task automatic settle;
    repeat (3) @(posedge clock);
    #1;
  endtask

  // Period of 16 clocks stays above the unlock threshold
  task automatic pfd(input int r, input int v);
    for (int i = 0; i < 16; i++) begin
      @(posedge clock);
      refTick <= (i == r);
      vcoTick <= (i == v);
    end
  endtask

  task automatic close(input int n);
    repeat (n) begin
      seed = xorshift(seed);
      pfd(0, int'(seed[1:0]));
    end
  endtask

  // Read results land one cycle after the strobe
  always @(posedge clock) begin
    if (rdPend) cmp(regRdData, expQ.pop_front());
    rdPend <= regRdEn;
  end

  initial begin
    #200000;
    err_count++;
    test_done;
  end

  initial begin
    {regAddr, regWrData, regWrEn, regRdEn, refTick, vcoTick, rdPend} = '0;
    resetn = 1'b0;
    err_count = 0;
    checks = 0;
    seed = 32'h202900ED;
    repeat (8) @(posedge clock);
    resetn <= 1'b1;
    rd(`OFS_RDIV_LO, 8'h01);
    rd(`OFS_ACNT, 8'h00);
    rd(`OFS_BCNT_LO, 8'h03);
    rd(`OFS_PRESCALE, 8'h00);
    rd(`OFS_LOCK_CTL, 8'h00);
    wr(10'h3FF, 8'hFF);
    rd(10'h3FF, 8'h00);
    wr(`OFS_BCNT_LO, 8'h02);
    rd(`OFS_LOCK_STAT, 8'h04);
    wr(`OFS_BCNT_LO, 8'h01);
    wr(`OFS_PRESCALE, 8'h03);
    wr(`OFS_ACNT, 8'h05);
    rd(`OFS_LOCK_STAT, 8'h04);
    wr(`OFS_ACNT, 8'h00);
    wr(`OFS_PRESCALE, 8'h00);
    rd(`OFS_LOCK_STAT, 8'h00);
    wr(`OFS_IRQ_STAT, 8'hFF);
    rd(`OFS_IRQ_STAT, 8'h00);
    wr(`OFS_IRQ_MASK, 8'h01);
    $display("test config done");
    close(4);
    pfd(0, 5);
    close(4);
    rd(`OFS_LOCK_STAT, 8'h00);
    close(1);
    rd(`OFS_LOCK_STAT, 8'h01);
    settle;
    cmp(irq, 8'h01);
    rd(`OFS_IRQ_STAT, 8'h01);
    pfd(0, 7);
    rd(`OFS_LOCK_STAT, 8'h01);
    pfd(0, 9);
    rd(`OFS_LOCK_STAT, 8'h00);
    rd(`OFS_IRQ_STAT, 8'h03);
    wr(`OFS_IRQ_STAT, 8'h01);
    settle;
    cmp(irq, 8'h00);
    rd(`OFS_IRQ_STAT, 8'h02);
    $display("test lock done");
    wr(`OFS_LOCK_CTL, 8'h10);
    repeat (5) pfd(0, 2);
    rd(`OFS_LOCK_STAT, 8'h00);
    wr(`OFS_STATUS_CTL, 8'h03);
    repeat (5) pfd(0, 2);
    rd(`OFS_LOCK_STAT, 8'h01);
    wr(`OFS_LOCK_CTL, 8'h00);
    wr(`OFS_STATUS_CTL, 8'h04);
    wr(`OFS_REFERENCE_MONITOR_PIN_CTL, 8'h01);
    settle;
    cmp({statusPin, refmonPin, ldPinOut, ldPinDriveN}, 8'h0E);
    wr(`OFS_LDPIN_CTL, 8'h04);
    repeat (20) @(posedge clock);
    settle;
    cmp({ldCurrentOn, ldPinDriveN}, 8'h03);
    rd(`OFS_LOCK_STAT, 8'h03);
    wr(`OFS_REFERENCE_MONITOR_PIN_CTL, 8'h02);
    settle;
    cmp(refmonPin, 8'h01);
    wr(`OFS_REFERENCE_MONITOR_PIN_CTL, 8'h03);
    wr(`OFS_STATUS_CTL, 8'h0C);
    settle;
    cmp({statusPin, refmonPin}, 8'h00);
    pfd(0, 9);
    settle;
    cmp({ldCurrentOn, ldPinDriveN, ldPinOut}, 8'h00);
    rd(`OFS_LOCK_STAT, 8'h00);
    $display("test pins done");
    wr(`OFS_LDPIN_CTL, 8'h01);
    pfd(0, 5);
    settle;
    cmp(pinLevel, 8'h01);
    wr(`OFS_LDPIN_CTL, 8'h02);
    pfd(0, 5);
    settle;
    cmp(ldPinDriveN, 8'h01);
    wr(`OFS_LDPIN_CTL, 8'h00);
    wr(`OFS_DELAY_CTL, 8'h04);
    repeat (5) pfd(4, 0);
    rd(`OFS_LOCK_STAT, 8'h01);
    wr(`OFS_LOCK_CTL, 8'h08);
    rd(`OFS_LOCK_STAT, 8'h00);
    $display("test delay done");
    wr(`OFS_DELAY_CTL, 8'h00);
    wr(`OFS_RDIV_LO, 8'h0C);
    wr(`OFS_PRESCALE, 8'h01);
    wr(`OFS_BCNT_LO, 8'h06);
    wr(`OFS_ACNT, 8'h05);
    wr(`OFS_LOCK_CTL, 8'h00);
    tick(96);
    rd(`OFS_LOCK_STAT, 8'h01);
    wr(`OFS_LOCK_CTL, 8'h08);
    wr(`OFS_PRESCALE, 8'h03);
    wr(`OFS_BCNT_LO, 8'h05);
    wr(`OFS_ACNT, 8'h02);
    wr(`OFS_LOCK_CTL, 8'h00);
    tick(96);
    rd(`OFS_LOCK_STAT, 8'h01);
    wr(`OFS_LOCK_CTL, 8'h08);
    wr(`OFS_RDIV_LO, 8'h10);
    wr(`OFS_PRESCALE, 8'h06);
    wr(`OFS_BCNT_LO, 8'h01);
    wr(`OFS_ACNT, 8'h01);
    wr(`OFS_LOCK_CTL, 8'h00);
    tick(96);
    rd(`OFS_LOCK_STAT, 8'h01);
    $display("test divide done");
    settle;
    test_done;
  end
endmodule
